// >>> core/cgrc_cfg.svh
// constants for the clock gate and reset control block
// assumes inclusion by bare name from core/ and testbench/ files
`ifndef CGRC_CFG_SVH
`define CGRC_CFG_SVH
`define CGRC_A_DIS_DLY 32'h51700008
`define CGRC_A_PM_DIS 32'h51700009
`define CGRC_A_GLB_PM 32'h5170000b
`define CGRC_A_CLKOFF 32'h51700010
`define CGRC_A_ACTIVE 32'h51700011
`define CGRC_A_DBG_MSK 32'h51700012
`define CGRC_A_ACK_MSK 32'h51700013
`define CGRC_A_DBG_CTL 32'h51700016
`define CGRC_DOM_N 64
`define CGRC_DLY_EN_BIT 1
`define CGRC_RST_DLY_W 20
`define CGRC_RST_DLY_DEF 20'h00100
`define CGRC_WORD_ZERO 64'h0000000000000000
`define CGRC_NSYNC 7
`define CGRC_P_SLOW 0
`define CGRC_P_PCI 1
`define CGRC_P_STBY_N 2
`define CGRC_P_WORK_N 3
`define CGRC_P_VSB_OK 4
`define CGRC_P_FAULT 5
`define CGRC_P_DISK 6
`endif

// >>> core/cgrc_pkg.sv
// types shared by the clock gate and reset control modules
// assumes cgrc_cfg.svh holds the numbers
package cgrc_pkg;
   typedef logic [63:0] cgrc_word_t;
   typedef enum logic [1:0] {SLP_IDLE, SLP_WAIT, SLP_ACK} cgrc_slp_e;
endpackage : cgrc_pkg

// >>> core/cgrc_rel_if.sv
// carrier between the sequencer and the reset release timer
// assumes both ends run on the system clock
`timescale 1ns/1ns
`include "cgrc_cfg.svh"
interface cgrc_rel_if;
   logic slow_tick;
   logic pci_tick;
   logic work_rst;
   logic sb_rst;
   logic prog_wr;
   logic [`CGRC_RST_DLY_W-1:0] prog_val;
   logic hold;
   modport ctl (output slow_tick, pci_tick, work_rst, sb_rst, prog_wr, prog_val,
      input hold);
   modport rel (input slow_tick, pci_tick, work_rst, sb_rst, prog_wr, prog_val,
      output hold);
endinterface : cgrc_rel_if

// >>> core/cgrc_rel.sv
// reset output release timer: slow-clock delay, then a pci clock edge
// assumes ticks are one-cycle pulses from synchronised clock pins
`timescale 1ns/1ns
`include "cgrc_cfg.svh"
module cgrc_rel (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // synchronous reset
   cgrc_rel_if.rel rel // sequencer side
);
   logic [`CGRC_RST_DLY_W-1:0] prog;
   logic [`CGRC_RST_DLY_W-1:0] cnt;

   // only the standby reset restores the default, so a new value
   // survives working resets and applies to the next one
   always_ff @(posedge clk_i) begin
      if (rst_i || rel.sb_rst) begin
         prog <= `CGRC_RST_DLY_DEF;
      end else if (rel.prog_wr) begin
         prog <= rel.prog_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rel.work_rst) begin
         rel.hold <= 1'b1;
         cnt <= prog;
      end else if (rel.hold && cnt != '0) begin
         if (rel.slow_tick) begin
            cnt <= cnt - 1'b1;
         end
      end else if (rel.hold && rel.pci_tick) begin
         rel.hold <= 1'b0;
      end
   end

   hold_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rel.work_rst) |-> rel.hold)
      else $error("release timer not holding after working reset");
   pci_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rel.hold) |-> $past(rel.pci_tick) && $past(cnt) == '0)
      else $error("reset output released off a pci edge or early");
endmodule : cgrc_rel

// >>> core/cgrc_top.sv
// clock gate masks, sleep acknowledge and reset sequencing
// assumes pins are asynchronous; sleep, debug and busy lines share the clock
`timescale 1ns/1ns
`include "cgrc_cfg.svh"
module cgrc_top #(
   parameter logic [`CGRC_DOM_N-1:0] CCU_MASK = '1, // domains with control
   parameter int DLY_W = 32 // sleep delay counter width
) (
   input wire logic SYS_CLK_I, // 20 MHz clock
   input wire logic SYS_RST_I, // sync reset, high
   input wire logic [31:0] MSR_ADDR_I, // register address
   input wire logic MSR_WR_I, // write strobe
   input wire logic MSR_RD_I, // read strobe
   input wire logic [63:0] MSR_WDATA_I, // write data
   output logic [63:0] MSR_RDATA_O, // read data
   output logic MSR_ACK_O, // access done
   input wire logic [`CGRC_DOM_N-1:0] DOM_BUSY_I, // domain busy
   output logic [`CGRC_DOM_N-1:0] DOM_CLK_EN_O, // domain clock enable
   input wire logic SLEEP_REQ_I, // sleep request
   output logic SLEEP_ACK_O, // sleep acknowledge
   input wire logic DEBUG_EVENT_I, // debug trigger
   input wire logic SLOW_STANDBY_CLOCK_I, // 32 kHz pin
   input wire logic PCI_CLK_I, // pci clock pin
   input wire logic STANDBY_RESET_IN_N_I, // standby reset pin
   input wire logic WORK_RESET_IN_N_I, // working reset pin
   input wire logic VSB_OK_I, // standby voltages ok
   input wire logic FAULT_I, // fault event
   input wire logic DISK_CORE_RST_I, // disk controller in reset
   input wire logic RST_DLY_WR_I, // load release delay
   input wire logic [`CGRC_RST_DLY_W-1:0] RST_DLY_VAL_I, // delay value
   output logic WORK_RESET_O, // working domain reset
   output logic RESET_OUT_N_O, // reset output pin
   output logic DISK_RESET_OUT_N_O, // disk reset pin
   output logic TAP_RESET_O, // tap controller reset
   output logic PG_STANDBY_O // standby power good
);
   localparam int NS = `CGRC_NSYNC;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] meta;
   logic [NS-1:0] pin_s;
   logic [NS-1:0] pin_d;
   logic sb_rst;
   logic pg_stby;
   logic standby;
   logic slow_tick;
   logic pci_tick;
   cgrc_pkg::cgrc_word_t dis_dly;
   cgrc_pkg::cgrc_word_t pm_dis;
   cgrc_pkg::cgrc_word_t glb_pm;
   cgrc_pkg::cgrc_word_t clkoff;
   cgrc_pkg::cgrc_word_t dbg_msk;
   cgrc_pkg::cgrc_word_t ack_msk;
   cgrc_pkg::cgrc_word_t dbg_ctl;
   cgrc_pkg::cgrc_word_t active;
   cgrc_pkg::cgrc_word_t next_active;
   cgrc_pkg::cgrc_word_t gate_off;
   cgrc_pkg::cgrc_slp_e slp;
   cgrc_pkg::cgrc_slp_e next_slp;
   logic [DLY_W-1:0] slp_cnt;
   logic dly_en;
   logic dbg_stop;
   logic dbg_live;
   logic mon_idle;
   logic dly_done;

   assign pin_raw = {DISK_CORE_RST_I, FAULT_I, VSB_OK_I, WORK_RESET_IN_N_I,
      STANDBY_RESET_IN_N_I, PCI_CLK_I, SLOW_STANDBY_CLOCK_I};

   // every pin passes two flops; the edge detector compares the second with a third
   for (genvar g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge SYS_CLK_I) begin
         if (SYS_RST_I) begin
            meta[g] <= 1'b0;
            pin_s[g] <= 1'b0;
            pin_d[g] <= 1'b0;
         end else begin
            meta[g] <= pin_raw[g];
            pin_s[g] <= meta[g];
            pin_d[g] <= pin_s[g];
         end
      end
   end

   assign slow_tick = pin_s[`CGRC_P_SLOW] & ~pin_d[`CGRC_P_SLOW];
   assign pci_tick = pin_s[`CGRC_P_PCI] & ~pin_d[`CGRC_P_PCI];
   assign pg_stby = pin_s[`CGRC_P_VSB_OK] & pin_s[`CGRC_P_STBY_N];
   assign sb_rst = SYS_RST_I | ~pg_stby;
   assign PG_STANDBY_O = pg_stby;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         standby <= 1'b1;
      end else begin
         standby <= ~pg_stby | ~pin_s[`CGRC_P_WORK_N] | pin_s[`CGRC_P_FAULT];
      end
   end

   assign WORK_RESET_O = standby;
   // under standby reset only the working input resets the tap, so scan can run
   assign TAP_RESET_O = (standby & pin_s[`CGRC_P_STBY_N]) | ~pin_s[`CGRC_P_WORK_N];
   assign DISK_RESET_OUT_N_O = ~(standby | pin_s[`CGRC_P_DISK]);

   cgrc_rel_if rel_if ();
   assign rel_if.slow_tick = slow_tick;
   assign rel_if.pci_tick = pci_tick;
   assign rel_if.work_rst = standby;
   assign rel_if.sb_rst = sb_rst;
   assign rel_if.prog_wr = RST_DLY_WR_I;
   assign rel_if.prog_val = RST_DLY_VAL_I;
   // assertion is combinational from standby so it needs no pci edge
   assign RESET_OUT_N_O = ~(standby | rel_if.hold);

   cgrc_rel u_rel (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .rel(rel_if.rel)
   );

   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst) begin
         dis_dly <= `CGRC_WORD_ZERO;
         pm_dis <= `CGRC_WORD_ZERO;
         glb_pm <= `CGRC_WORD_ZERO;
         clkoff <= `CGRC_WORD_ZERO;
         dbg_msk <= `CGRC_WORD_ZERO;
         ack_msk <= `CGRC_WORD_ZERO;
         dbg_ctl <= `CGRC_WORD_ZERO;
      end else if (MSR_WR_I) begin
         // the status register ignores writes
         case (MSR_ADDR_I)
            `CGRC_A_DIS_DLY: dis_dly <= MSR_WDATA_I;
            `CGRC_A_PM_DIS: pm_dis <= MSR_WDATA_I;
            `CGRC_A_GLB_PM: glb_pm <= MSR_WDATA_I;
            `CGRC_A_CLKOFF: clkoff <= MSR_WDATA_I;
            `CGRC_A_DBG_MSK: dbg_msk <= MSR_WDATA_I;
            `CGRC_A_ACK_MSK: ack_msk <= MSR_WDATA_I;
            `CGRC_A_DBG_CTL: dbg_ctl <= MSR_WDATA_I;
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst) begin
         MSR_RDATA_O <= `CGRC_WORD_ZERO;
         MSR_ACK_O <= 1'b0;
      end else begin
         MSR_ACK_O <= MSR_WR_I | MSR_RD_I;
         if (MSR_RD_I) begin
            case (MSR_ADDR_I)
               `CGRC_A_DIS_DLY: MSR_RDATA_O <= dis_dly;
               `CGRC_A_PM_DIS: MSR_RDATA_O <= pm_dis;
               `CGRC_A_GLB_PM: MSR_RDATA_O <= glb_pm;
               `CGRC_A_CLKOFF: MSR_RDATA_O <= clkoff;
               `CGRC_A_ACTIVE: MSR_RDATA_O <= active;
               `CGRC_A_DBG_MSK: MSR_RDATA_O <= dbg_msk;
               `CGRC_A_ACK_MSK: MSR_RDATA_O <= ack_msk;
               `CGRC_A_DBG_CTL: MSR_RDATA_O <= dbg_ctl;
               default: MSR_RDATA_O <= `CGRC_WORD_ZERO;
            endcase
         end
      end
   end

   // debug events only count while debug clocks are on; the stop latches
   // until software rewrites the debug stop mask, and a new event wins
   assign dbg_live = DEBUG_EVENT_I & (dbg_ctl != `CGRC_WORD_ZERO);
   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst) begin
         dbg_stop <= 1'b0;
      end else if (dbg_live) begin
         dbg_stop <= 1'b1;
      end else if (MSR_WR_I && MSR_ADDR_I == `CGRC_A_DBG_MSK) begin
         dbg_stop <= 1'b0;
      end
   end

   assign dly_en = glb_pm[`CGRC_DLY_EN_BIT];
   assign mon_idle = (active & ack_msk) == `CGRC_WORD_ZERO;
   assign dly_done = slp_cnt >= dis_dly[DLY_W-1:0];

   always_comb begin
      next_slp = slp;
      unique case (slp)
         cgrc_pkg::SLP_IDLE: begin
            if (SLEEP_REQ_I) begin
               next_slp = cgrc_pkg::SLP_WAIT;
            end
         end
         cgrc_pkg::SLP_WAIT: begin
            if (!SLEEP_REQ_I) begin
               next_slp = cgrc_pkg::SLP_IDLE;
            end else if (dly_en ? dly_done : mon_idle) begin
               next_slp = cgrc_pkg::SLP_ACK;
            end
         end
         cgrc_pkg::SLP_ACK: begin
            if (!SLEEP_REQ_I) begin
               next_slp = cgrc_pkg::SLP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst) begin
         slp <= cgrc_pkg::SLP_IDLE;
      end else begin
         slp <= next_slp;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst || slp != cgrc_pkg::SLP_WAIT) begin
         slp_cnt <= '0;
      end else if (pci_tick && !dly_done) begin
         slp_cnt <= slp_cnt + 1'b1;
      end
   end

   assign SLEEP_ACK_O = (slp == cgrc_pkg::SLP_ACK);

   // sleep-disable clocks go off in the ack state, never before it
   always_comb begin
      gate_off = clkoff;
      if (dbg_stop) begin
         gate_off = gate_off | dbg_msk;
      end
      if (slp == cgrc_pkg::SLP_ACK) begin
         gate_off = gate_off | pm_dis;
      end
   end

   assign next_active = DOM_CLK_EN_O & DOM_BUSY_I;

   always_ff @(posedge SYS_CLK_I) begin
      if (sb_rst) begin
         DOM_CLK_EN_O <= '1;
         active <= `CGRC_WORD_ZERO;
      end else begin
         DOM_CLK_EN_O <= ~gate_off | ~CCU_MASK;
         active <= next_active;
      end
   end

   standby_fault_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      pin_s[`CGRC_P_FAULT] || !pin_s[`CGRC_P_STBY_N] |=> standby && WORK_RESET_O)
      else $error("fault or standby input did not force standby");
   resets_low_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      standby |-> !RESET_OUT_N_O && !DISK_RESET_OUT_N_O && (TAP_RESET_O || !pin_s[`CGRC_P_STBY_N]))
      else $error("a reset output released during standby");
   clkoff_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      ##1 ((DOM_CLK_EN_O & $past(clkoff) & CCU_MASK) == `CGRC_WORD_ZERO))
      else $error("forced-off clock still enabled");
   no_ccu_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      ##1 ((~DOM_CLK_EN_O & ~CCU_MASK) == `CGRC_WORD_ZERO))
      else $error("domain without clock control was gated");
   status_read_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      MSR_RD_I && MSR_ADDR_I == `CGRC_A_ACTIVE |=> MSR_ACK_O && MSR_RDATA_O == $past(active))
      else $error("status read returned wrong value");
   ack_mask_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      slp == cgrc_pkg::SLP_WAIT && SLEEP_REQ_I && !dly_en && mon_idle |=> SLEEP_ACK_O)
      else $error("sleep ack missing with all monitored clocks idle");
   no_early_ack_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      slp == cgrc_pkg::SLP_WAIT && !dly_en && !mon_idle |=> !SLEEP_ACK_O)
      else $error("sleep ack while a monitored clock runs");
   delay_ack_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      slp == cgrc_pkg::SLP_WAIT && dly_en && !dly_done |=> !SLEEP_ACK_O)
      else $error("sleep ack before the disable delay ran out");
   ack_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      SLEEP_ACK_O && SLEEP_REQ_I |=> SLEEP_ACK_O)
      else $error("sleep ack dropped while request still high");
   sleep_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      SLEEP_ACK_O ##1 SLEEP_ACK_O |-> ((DOM_CLK_EN_O & $past(pm_dis) & CCU_MASK) == `CGRC_WORD_ZERO))
      else $error("sleep-disable clock enabled after ack");
   dbg_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      dbg_live && !MSR_WR_I ##1 !MSR_WR_I |=>
      ((DOM_CLK_EN_O & dbg_msk & CCU_MASK) == `CGRC_WORD_ZERO))
      else $error("debug stop did not gate masked clocks");
   tap_rst_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      !pin_s[`CGRC_P_WORK_N] |-> TAP_RESET_O ##1 (TAP_RESET_O || !pin_s[`CGRC_P_STBY_N]))
      else $error("tap reset released with working input low");

   ack_seen_c: cover property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      !dly_en && $rose(SLEEP_ACK_O));
   delay_ack_c: cover property (@(posedge SYS_CLK_I) disable iff (sb_rst)
      dly_en && $rose(SLEEP_ACK_O));
   release_c: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $rose(RESET_OUT_N_O));
   dbg_c: cover property (@(posedge SYS_CLK_I) disable iff (sb_rst) $rose(dbg_stop));
endmodule : cgrc_top

// >>> testbench/cgrc_pm_model.sv
// model of the power management controller, reset pins and disk controller
// assumes the bench calls its tasks just after a system clock edge
`timescale 1ns/1ns
module cgrc_pm_model #(
   parameter int SLOW_HALF = 500, // scaled standby clock half period in ns
   parameter int PCI_HALF = 150 // pci clock half period in ns
) (
   input wire logic clk_i, // system clock
   input wire logic work_reset_i, // working reset from the block
   output logic slow_clk_o, // standby clock pin
   output logic pci_clk_o, // pci clock pin
   output logic stby_n_o, // standby reset pin
   output logic work_n_o, // working reset pin
   output logic vsb_ok_o, // standby voltages in range
   output logic fault_o, // fault level
   output logic disk_rst_o, // disk controller still in reset
   output logic sleep_req_o // sleep request
);
   logic [2:0] disk_hold;
   initial begin
      slow_clk_o = 1'b0;
      pci_clk_o = 1'b0;
      disk_hold = 3'h7;
      sleep_req_o = 1'b0;
      set_pins(1'b1, 1'b1, 1'b1, 1'b0);
   end
   // both clocks run free, their edges landing on system clock falling edges
   always #SLOW_HALF slow_clk_o = ~slow_clk_o;
   always #PCI_HALF pci_clk_o = ~pci_clk_o;
   // controller leaves reset a few cycles after the working reset drops
   always @(posedge clk_i) disk_hold <= {disk_hold[1:0], work_reset_i};
   assign disk_rst_o = work_reset_i | (|disk_hold);
   task automatic set_pins(input logic s_n, input logic w_n, input logic v, input logic f);
      stby_n_o = s_n;
      work_n_o = w_n;
      vsb_ok_o = v;
      fault_o = f;
   endtask : set_pins
   // withdrawn only once the bench has seen the acknowledge
   task automatic set_req(input logic r);
      sleep_req_o = r;
   endtask : set_req
   // standby pin held low for the whole scan, working pin pulsed
   task automatic scan_pulse();
      stby_n_o = 1'b0;
      work_n_o = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      work_n_o = 1'b1;
   endtask : scan_pulse
endmodule : cgrc_pm_model

// >>> testbench/test_clock_gate_reset_control.sv
// self-checking bench for the clock gate and reset control block
// assumes the partner model drives all pins; registers reached by strobe and ack
`timescale 1ns/1ns
`include "cgrc_cfg.svh"
module test_clock_gate_reset_control;
   localparam logic [63:0] CLOCK_CONTROL_UNIT = 64'hfffffffffffffff0;
   localparam logic [31:0] REGS [9] = '{`CGRC_A_DIS_DLY, `CGRC_A_PM_DIS, `CGRC_A_GLB_PM,
      `CGRC_A_CLKOFF, `CGRC_A_ACTIVE, `CGRC_A_DBG_MSK, `CGRC_A_ACK_MSK, `CGRC_A_DBG_CTL,
      32'h51700014};
   logic clk, rst, wr, rd, ack, req, sack, dbg_ev, slow, pci, stby_n, work_n, vsb, fault;
   logic disk_core, dly_wr, work_rst, rst_out_n, disk_n, tap, pg;
   logic [31:0] addr;
   logic [`CGRC_RST_DLY_W-1:0] dly_val;
   cgrc_pkg::cgrc_word_t wdata, rdata, busy, clk_en;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   cgrc_top #(.CCU_MASK(CLOCK_CONTROL_UNIT), .DLY_W(32)) cgrc_top_i (.SYS_CLK_I(clk), .SYS_RST_I(rst),
      .MSR_ADDR_I(addr), .MSR_WR_I(wr), .MSR_RD_I(rd), .MSR_WDATA_I(wdata),
      .MSR_RDATA_O(rdata), .MSR_ACK_O(ack), .DOM_BUSY_I(busy), .DOM_CLK_EN_O(clk_en),
      .SLEEP_REQ_I(req), .SLEEP_ACK_O(sack), .DEBUG_EVENT_I(dbg_ev),
      .SLOW_STANDBY_CLOCK_I(slow), .PCI_CLK_I(pci), .STANDBY_RESET_IN_N_I(stby_n),
      .WORK_RESET_IN_N_I(work_n), .VSB_OK_I(vsb), .FAULT_I(fault),
      .DISK_CORE_RST_I(disk_core), .RST_DLY_WR_I(dly_wr), .RST_DLY_VAL_I(dly_val),
      .WORK_RESET_O(work_rst), .RESET_OUT_N_O(rst_out_n), .DISK_RESET_OUT_N_O(disk_n),
      .TAP_RESET_O(tap), .PG_STANDBY_O(pg));
   cgrc_pm_model cgrc_pm_model_i (.clk_i(clk), .work_reset_i(work_rst), .slow_clk_o(slow),
      .pci_clk_o(pci), .stby_n_o(stby_n), .work_n_o(work_n), .vsb_ok_o(vsb),
      .fault_o(fault), .disk_rst_o(disk_core), .sleep_req_o(req));
   always #25 clk = ~clk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // a hung wait would otherwise never reach the report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic tick(input int k = 1);
      repeat (k) begin
         @(posedge clk);
         #1;
      end
   endtask : tick
   task automatic chk(input string what, input cgrc_pkg::cgrc_word_t exp,
      input cgrc_pkg::cgrc_word_t got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_bit(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         tick();
         n++;
      end
   endtask : wait_bit
   // the strobe is taken on one edge; the ack and read data stand the cycle after
   task automatic msr_wr(input logic [31:0] a, input cgrc_pkg::cgrc_word_t d,
      input logic exp_ack = 1'b1);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick();
      wr = 1'b0;
      chk("write ack", 64'(exp_ack), 64'(ack));
      tick();
   endtask : msr_wr
   task automatic msr_rd(input logic [31:0] a, input cgrc_pkg::cgrc_word_t exp);
      addr = a;
      rd = 1'b1;
      tick();
      rd = 1'b0;
      chk("read ack", 64'h1, 64'(ack));
      chk("read data", exp, rdata);
      tick();
   endtask : msr_rd
   task automatic release_time(input int lo, input int hi);
      wait_bit(work_rst, 1'b0, 20);
      chk("disk reset after release", 64'h0, 64'(disk_n));
      wait_bit(rst_out_n, 1'b1, hi + 5);
      chk("release delay in range", 64'h1, 64'(n >= lo && n <= hi));
      chk("disk reset released", 64'h1, 64'(disk_n));
   endtask : release_time
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 32'h0;
      wdata = 64'h0;
      busy = 64'h0;
      dbg_ev = 1'b0;
      dly_wr = 1'b0;
      dly_val = 20'h00000;
      tick(6);
      chk("working reset", 64'h1, 64'(work_rst));
      chk("reset out", 64'h0, 64'(rst_out_n));
      chk("tap reset", 64'h1, 64'(tap));
      chk("power good", 64'h0, 64'(pg));
      rst = 1'b0;
      wait_bit(pg, 1'b1, 20);
      chk("power good", 64'h1, 64'(pg));
      for (int i = 0; i < 9; i++) begin
         msr_rd(REGS[i], 64'h0);
         msr_wr(REGS[i], 64'h5a5a0000c3c30000 | 64'(i));
         msr_rd(REGS[i], (i == 4 || i == 8) ? 64'h0 : 64'h5a5a0000c3c30000 | 64'(i));
         msr_wr(REGS[i], 64'h0);
      end
      busy = 64'hffff;
      tick();
      msr_rd(`CGRC_A_ACTIVE, 64'hffff);
      msr_wr(`CGRC_A_CLKOFF, 64'hffffffffffffffff);
      tick();
      chk("forced off", ~CLOCK_CONTROL_UNIT, clk_en);
      msr_rd(`CGRC_A_ACTIVE, 64'hf);
      msr_wr(`CGRC_A_CLKOFF, 64'h0);
      msr_wr(`CGRC_A_DBG_CTL, 64'h1);
      msr_wr(`CGRC_A_DBG_MSK, 64'hff00);
      dbg_ev = 1'b1;
      tick();
      dbg_ev = 1'b0;
      tick(2);
      chk("debug stop", ~64'hff00, clk_en);
      msr_wr(`CGRC_A_DBG_MSK, 64'h0);
      msr_wr(`CGRC_A_DBG_CTL, 64'h0);
      chk("debug stop cleared", ~64'h0, clk_en);
      msr_wr(`CGRC_A_DIS_DLY, 64'hffffffff);
      msr_wr(`CGRC_A_ACK_MSK, 64'h30);
      msr_wr(`CGRC_A_PM_DIS, 64'hf00);
      busy = 64'h10;
      cgrc_pm_model_i.set_req(1'b1);
      tick(20);
      chk("ack while busy", 64'h0, 64'(sack));
      chk("clocks before ack", ~64'h0, clk_en);
      busy = 64'h0;
      wait_bit(sack, 1'b1, 4);
      chk("ack when idle", 64'h1, 64'(sack));
      tick();
      chk("sleep gating", ~64'hf00, clk_en);
      tick(10);
      chk("ack held", 64'h1, 64'(sack));
      cgrc_pm_model_i.set_req(1'b0);
      tick(2);
      chk("ack dropped", 64'h0, 64'(sack));
      tick();
      chk("clocks back", ~64'h0, clk_en);
      msr_wr(`CGRC_A_GLB_PM, 64'h2);
      msr_wr(`CGRC_A_DIS_DLY, 64'h4);
      busy = 64'h10;
      cgrc_pm_model_i.set_req(1'b1);
      tick(8);
      chk("ack before delay", 64'h0, 64'(sack));
      wait_bit(sack, 1'b1, 40);
      chk("ack after delay", 64'h1, 64'(n >= 9 && sack === 1'b1));
      tick();
      chk("delay gating", ~64'hf00, clk_en);
      cgrc_pm_model_i.set_req(1'b0);
      tick(3);
      busy = 64'h0;
      msr_wr(`CGRC_A_GLB_PM, 64'h0);
      dly_val = 20'h00004;
      dly_wr = 1'b1;
      tick();
      dly_wr = 1'b0;
      cgrc_pm_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
      tick(4);
      chk("working reset", 64'h1, 64'(work_rst));
      chk("reset out", 64'h0, 64'(rst_out_n));
      chk("disk reset", 64'h0, 64'(disk_n));
      chk("tap reset", 64'h1, 64'(tap));
      cgrc_pm_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      release_time(60, 92);
      chk("tap released", 64'h0, 64'(tap));
      cgrc_pm_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
      tick(4);
      chk("fault reset", 64'h1, 64'(work_rst));
      cgrc_pm_model_i.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
      tick(4);
      chk("power good low voltage", 64'h0, 64'(pg));
      msr_wr(`CGRC_A_CLKOFF, 64'h100, 1'b0);
      cgrc_pm_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      wait_bit(pg, 1'b1, 20);
      msr_rd(`CGRC_A_CLKOFF, 64'h0);
      msr_wr(`CGRC_A_CLKOFF, 64'h100);
      cgrc_pm_model_i.scan_pulse();
      chk("power good scan", 64'h0, 64'(pg));
      chk("tap reset scan", 64'h1, 64'(tap));
      chk("clocks after standby", ~64'h0, clk_en);
      tick(3);
      chk("tap free during scan", 64'h0, 64'(tap));
      chk("power good still low", 64'h0, 64'(pg));
      cgrc_pm_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      wait_bit(pg, 1'b1, 20);
      msr_rd(`CGRC_A_CLKOFF, 64'h0);
      release_time(5090, 5140);
      give_verdict();
   end
endmodule : test_clock_gate_reset_control
